// ### logic/bus_cycle_sequencer.sv
`timescale 1ns/1ps
`include "bus_seq_cfg.svh"

// Function
// - accumulator store is four cycles; opcode then address byte read, valid high.
// - accumulator store cycle 3 drives destination, valid low, read.
// - accumulator store cycle 4 writes accumulator to destination, valid high.
// - wide store is five cycles; opcode then address byte read, valid high.
// - wide store cycle 3 drives operand address, valid low, read.
// - wide store cycle 4 writes high byte to operand address.
// - wide store cycle 5 writes low byte to operand address plus one.
// - wide load cycle 4 reads low byte from operand address plus one.
// - indexed cycle 3 drives index register, valid low, read.
// - indexed jump is four cycles; cycle 4 index plus offset, no carry, valid low.
module bus_cycle_sequencer (
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  rst,
    // instruction start
    input  wire logic                  start,
    input  wire logic [1:0]            kind,
    input  wire logic [15:0]           opcodeAddress,
    // core data paths
    input  wire logic [7:0]            accumulator,
    input  wire logic [15:0]           wideRegister,
    input  wire logic [15:0]           indexValue,
    // memory bus
    input  wire logic [7:0]            dataIn,
    output logic                       valid_address_qualifier,
    output logic      [15:0]           addressBus,
    output logic                       readSelect,
    output logic      [7:0]            dataOut,
    output logic                       dataOutEnable,
    // status
    output logic                       busy,
    output logic                       done
);
    // ------------------------------------------------------------------
    // sequence state
    // ------------------------------------------------------------------
    bus_seq_pkg::step_type step;
    bus_seq_pkg::step_type next_step;
    logic [2:0]            cycle;
    logic [2:0]            next_cycle;
    logic [1:0]            curKind;
    logic [1:0]            next_curKind;
    logic [15:0]           opAddr;
    logic [15:0]           next_opAddr;
    logic [7:0]            operandByte;
    logic [7:0]            next_operandByte;
    logic [2:0]            lastCycle;
    logic [15:0]           address;
    logic                  next_valid;
    logic                  next_read;
    logic [15:0]           next_address;
    logic [7:0]            next_dataOut;
    logic                  next_done;

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    function automatic logic [2:0] cycles_of(input logic [1:0] k);
        case (k)
            `KIND_STORE_ACC:  cycles_of = `CYCLES_STORE_ACC;
            `KIND_STORE_WIDE: cycles_of = `CYCLES_STORE_WIDE;
            `KIND_LOAD_WIDE:  cycles_of = `CYCLES_LOAD_WIDE;
            default:          cycles_of = `CYCLES_JUMP_INDEX;
        endcase
    endfunction : cycles_of

    function automatic bus_seq_pkg::step_type step_of(input logic [2:0] c);
        case (c)
            3'h1:    step_of = bus_seq_pkg::STEP1_type;
            3'h2:    step_of = bus_seq_pkg::STEP2_type;
            3'h3:    step_of = bus_seq_pkg::STEP3_type;
            3'h4:    step_of = bus_seq_pkg::STEP4_type;
            3'h5:    step_of = bus_seq_pkg::STEP5_type;
            default: step_of = bus_seq_pkg::IDLE_type;
        endcase
    endfunction : step_of

    assign lastCycle = cycles_of(curKind);

    // ------------------------------------------------------------------
    // next bus cycle
    // ------------------------------------------------------------------
    always_comb begin
        next_step        = step;
        next_cycle       = cycle;
        next_curKind     = curKind;
        next_opAddr      = opAddr;
        next_operandByte = operandByte;
        next_done        = 1'b0;
        if (step == bus_seq_pkg::IDLE_type || cycle == lastCycle) begin
            next_done = (step != bus_seq_pkg::IDLE_type);
            if (start) begin
                next_cycle   = 3'h1;
                next_curKind = kind;
                next_opAddr  = opcodeAddress;
                next_step    = bus_seq_pkg::STEP1_type;
            end else begin
                next_cycle = 3'h0;
                next_step  = bus_seq_pkg::IDLE_type;
            end
        end else begin
            // the byte after the opcode is captured at the end of cycle 2
            if (cycle == 3'h2) begin
                next_operandByte = dataIn;
            end
            next_cycle = cycle + 3'h1;
            next_step  = step_of(cycle + 3'h1);
        end
    end

    // address is formed from next-state values so it lands together with its cycle
    bus_addr_gen u_bus_addr_gen (
        .cycleNumber   (next_cycle),
        .kind          (next_curKind),
        .opcodeAddress (next_opAddr),
        .indexValue    (indexValue),
        .operandByte   (next_operandByte),
        .address       (address)
    );

    // ------------------------------------------------------------------
    // bus outputs for the coming cycle
    // ------------------------------------------------------------------
    always_comb begin
        next_valid   = 1'b0;
        next_read    = 1'b1;
        next_address = addressBus;
        next_dataOut = dataOut;
        if (next_step != bus_seq_pkg::IDLE_type) begin
            next_address = address;
            case (next_cycle)
                3'h1, 3'h2: next_valid = 1'b1;
                3'h3:       next_valid = 1'b0;
                3'h4: begin
                    case (next_curKind)
                        `KIND_STORE_ACC: begin
                            next_valid   = 1'b1;
                            next_read    = 1'b0;
                            next_dataOut = accumulator;
                        end
                        `KIND_STORE_WIDE: begin
                            next_valid   = 1'b1;
                            next_read    = 1'b0;
                            next_dataOut = wideRegister[15:8];
                        end
                        `KIND_LOAD_WIDE: next_valid = 1'b1;
                        default:         next_valid = 1'b0;
                    endcase
                end
                3'h5: begin
                    next_valid   = 1'b1;
                    next_read    = 1'b0;
                    next_dataOut = wideRegister[7:0];
                end
                default: next_valid = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            step                    <= bus_seq_pkg::IDLE_type;
            cycle                   <= 3'h0;
            curKind                 <= 2'h0;
            opAddr                  <= `RESET_ADDRESS;
            operandByte             <= 8'h00;
            valid_address_qualifier <= 1'b0;
            readSelect              <= 1'b1;
            addressBus              <= `RESET_ADDRESS;
            dataOut                 <= 8'h00;
            done                    <= 1'b0;
        end else begin
            step                    <= next_step;
            cycle                   <= next_cycle;
            curKind                 <= next_curKind;
            opAddr                  <= next_opAddr;
            operandByte             <= next_operandByte;
            valid_address_qualifier <= next_valid;
            readSelect              <= next_read;
            addressBus              <= next_address;
            dataOut                 <= next_dataOut;
            done                    <= next_done;
        end
    end

    // ------------------------------------------------------------------
    // status outputs
    // ------------------------------------------------------------------
    // memory ignores unqualified cycles, so idle parks with valid low
    assign dataOutEnable = ~readSelect;
    assign busy          = (step != bus_seq_pkg::IDLE_type);

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    fetch_valid_a: assert property (
        (cycle == 3'h1 || cycle == 3'h2) |-> valid_address_qualifier && readSelect)
        else $error("fetch cycle not a valid read");
    acc_length_a: assert property (
        (cycle == 3'h4 && curKind == `KIND_STORE_ACC) |=> cycle != 3'h5)
        else $error("accumulator store longer than four cycles");
    dummy_read_a: assert property (
        cycle == 3'h3 |-> !valid_address_qualifier && readSelect)
        else $error("cycle 3 not a dummy read");
    acc_write_a: assert property (
        (cycle == 3'h4 && curKind == `KIND_STORE_ACC) |->
        valid_address_qualifier && !readSelect && dataOut == $past(accumulator) &&
        addressBus == {8'h00, operandByte})
        else $error("accumulator write wrong");
    wide_length_a: assert property (
        (cycle == 3'h1 && curKind == `KIND_STORE_WIDE) |-> ##4 cycle == 3'h5)
        else $error("wide store not five cycles");
    wide_addr_a: assert property (
        (cycle == 3'h3 && curKind == `KIND_STORE_WIDE) |-> addressBus == {8'h00, operandByte})
        else $error("wide dummy address wrong");
    high_write_a: assert property (
        (cycle == 3'h4 && curKind == `KIND_STORE_WIDE) |->
        !readSelect && valid_address_qualifier && dataOut == $past(wideRegister[15:8]))
        else $error("high byte write wrong");
    low_write_a: assert property (
        (cycle == 3'h4 && curKind == `KIND_STORE_WIDE) |=>
        cycle == 3'h5 && addressBus == $past(addressBus) + 16'h0001 && !readSelect)
        else $error("low byte write wrong");
    load_low_a: assert property (
        (cycle == 3'h4 && curKind == `KIND_LOAD_WIDE) |->
        readSelect && valid_address_qualifier && addressBus == {8'h00, operandByte} + 16'h0001)
        else $error("load low byte wrong");
    index_addr_a: assert property (
        (cycle == 3'h3 && curKind == `KIND_JUMP_INDEX) |-> addressBus == $past(indexValue))
        else $error("index address wrong");
    jump_target_a: assert property (
        (cycle == 3'h4 && curKind == `KIND_JUMP_INDEX) |->
        !valid_address_qualifier && addressBus[7:0] == $past(indexValue[7:0]) + operandByte &&
        addressBus[15:8] == $past(indexValue[15:8]))
        else $error("jump cycle 4 wrong");
    jump_length_a: assert property (
        (cycle == 3'h1 && curKind == `KIND_JUMP_INDEX) |-> ##3 (cycle == 3'h4 && readSelect))
        else $error("indexed jump cycle 4 misplaced");

    // ------------------------------------------------------------------
    // coverage of the main sequences
    // ------------------------------------------------------------------
    acc_store_c: cover property (cycle == 3'h4 && curKind == `KIND_STORE_ACC);
    wide_store_c: cover property (cycle == 3'h5 && curKind == `KIND_STORE_WIDE);
    jump_c: cover property (cycle == 3'h4 && curKind == `KIND_JUMP_INDEX);
    back_to_back_c: cover property (done && cycle == 3'h1);
endmodule : bus_cycle_sequencer

// ### logic/bus_seq_cfg.svh
`ifndef BUS_SEQ_CFG_SVH
`define BUS_SEQ_CFG_SVH

// instruction kinds handled by the sequencer
`define KIND_STORE_ACC   2'h0
`define KIND_STORE_WIDE  2'h1
`define KIND_LOAD_WIDE   2'h2
`define KIND_JUMP_INDEX  2'h3

// bus cycles per instruction
`define CYCLES_STORE_ACC  3'h4
`define CYCLES_STORE_WIDE 3'h5
`define CYCLES_LOAD_WIDE  3'h4
`define CYCLES_JUMP_INDEX 3'h4

`define RESET_ADDRESS 16'h0000

`endif

// ### logic/bus_seq_pkg.sv
package bus_seq_pkg;
    typedef logic [1:0] kind_type;
    // gray coded along the step order
    typedef enum logic [2:0] {
        IDLE_type   = 3'h0,
        STEP1_type  = 3'h1,
        STEP2_type  = 3'h3,
        STEP3_type  = 3'h2,
        STEP4_type  = 3'h6,
        STEP5_type  = 3'h7
    } step_type;
endpackage : bus_seq_pkg

// ### logic/bus_addr_gen.sv
`timescale 1ns/1ps
`include "bus_seq_cfg.svh"

// address selection for one bus cycle
module bus_addr_gen (
    // selection
    input  wire logic                  [2:0]  cycleNumber,
    input  wire logic                  [1:0]  kind,
    // sources
    input  wire logic                  [15:0] opcodeAddress,
    input  wire logic                  [15:0] indexValue,
    input  wire logic                  [7:0]  operandByte,
    // result
    output logic                       [15:0] address
);
    always_comb begin
        address = opcodeAddress;
        case (cycleNumber)
            3'h1: address = opcodeAddress;
            3'h2: address = opcodeAddress + 16'h0001;
            3'h3: begin
                if (kind == `KIND_JUMP_INDEX) begin
                    address = indexValue;
                end else begin
                    address = {8'h00, operandByte};
                end
            end
            3'h4: begin
                if (kind == `KIND_JUMP_INDEX) begin
                    // no carry out of the low byte
                    address = {indexValue[15:8], indexValue[7:0] + operandByte};
                end else if (kind == `KIND_LOAD_WIDE) begin
                    address = {8'h00, operandByte} + 16'h0001;
                end else begin
                    address = {8'h00, operandByte};
                end
            end
            3'h5: address = {8'h00, operandByte} + 16'h0001;
            default: address = opcodeAddress;
        endcase
    end
endmodule : bus_addr_gen

// ### verification/bus_memory_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// memory and peripherals on the far side
// ----------------------------------------
module bus_memory_model (
    // bus from the sequencer
    input  wire logic        clock,
    input  wire logic        valid,
    input  wire logic [15:0] address,
    input  wire logic        readSelect,
    input  wire logic [7:0]  writeData,
    // read data back
    output logic      [7:0]  readData
);
    logic [7:0] mem [0:65535];
    logic [7:0] lastOut;

    initial begin
        lastOut = 8'h00;
        for (int i = 0; i < 65536; i++) begin
            mem[i] = i[7:0] ^ i[15:8] ^ 8'h3c;
        end
    end

    // an unqualified cycle gets no answer, so the line carries the inverse of the byte it carried the cycle before
    assign readData = (valid && readSelect) ? mem[address] : ~lastOut;

    always @(posedge clock) begin
        lastOut <= readData;
        if (valid && !readSelect) begin
            mem[address] <= writeData;
        end
    end
endmodule : bus_memory_model

// ### verification/bus_cycle_sequencer_direct_indexed_tb_top.sv
`timescale 1ns/1ps

module bus_cycle_sequencer_direct_indexed_tb_top;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        start = 1'b0;
    logic [1:0]  kind = 2'h0;
    logic [15:0] opcodeAddress = 16'h0000;
    logic [7:0]  accumulator = 8'h00;
    logic [15:0] wideRegister = 16'h0000;
    logic [15:0] indexValue = 16'h0000;
    logic [7:0]  dataIn;
    logic        vaq;
    logic [15:0] addressBus;
    logic        readSelect;
    logic [7:0]  dataOut;
    logic        busy;
    logic        done;
    logic [26:0] notes [$];
    logic [26:0] oldest;
    int          miscompares = 0;
    int          samplesChecked = 0;
    int          dones = 0;
    int          ops = 0;

    always #25 clock = ~clock;

    bus_cycle_sequencer u_bus_cycle_sequencer (.clock(clock), .rst(rst), .start(start),
        .kind(kind), .opcodeAddress(opcodeAddress), .accumulator(accumulator),
        .wideRegister(wideRegister), .indexValue(indexValue), .dataIn(dataIn),
        .valid_address_qualifier(vaq), .addressBus(addressBus), .readSelect(readSelect),
        .dataOut(dataOut), .dataOutEnable(), .busy(busy), .done(done));

    bus_memory_model u_bus_memory_model (.clock(clock), .valid(vaq), .address(addressBus),
        .readSelect(readSelect), .writeData(dataOut), .readData(dataIn));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    function automatic logic [7:0] pattern(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction : pattern

    task automatic check(input logic [25:0] seen, input logic [25:0] want);
        samplesChecked++;
        if (seen !== want) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check

    task automatic note(input logic v, input logic r, input logic [15:0] a,
                        input logic chk, input logic [7:0] d);
        notes.push_back({chk, v, r, a, d});
    endtask : note

    // returns at the edge where a following start would land on the last cycle
    task automatic run_op(input logic [1:0] k, input logic [15:0] op, input logic [7:0] acc,
                          input logic [15:0] wide, input logic [15:0] idx, input logic poke);
        logic [15:0] b;
        int          n;
        b = {8'h00, pattern(op + 16'h0001)};
        n = (k == 2'h1) ? 5 : 4;
        note(1'b1, 1'b1, op, 1'b0, 8'h00);
        note(1'b1, 1'b1, op + 16'h0001, 1'b0, 8'h00);
        if (k == 2'h3) begin
            note(1'b0, 1'b1, idx, 1'b0, 8'h00);
            note(1'b0, 1'b1, {idx[15:8], idx[7:0] + b[7:0]}, 1'b0, 8'h00);
        end else begin
            note(1'b0, 1'b1, b, 1'b0, 8'h00);
        end
        if (k == 2'h0) note(1'b1, 1'b0, b, 1'b1, acc);
        if (k == 2'h1) begin
            note(1'b1, 1'b0, b, 1'b1, wide[15:8]);
            note(1'b1, 1'b0, b + 16'h0001, 1'b1, wide[7:0]);
        end
        if (k == 2'h2) note(1'b1, 1'b1, b + 16'h0001, 1'b0, 8'h00);
        start <= 1'b1;
        kind <= k;
        opcodeAddress <= op;
        accumulator <= acc;
        wideRegister <= wide;
        indexValue <= idx;
        @(posedge clock);
        start <= 1'b0;
        ops++;
        @(posedge clock);
        // a start in mid-sequence must be ignored
        if (poke) begin
            start <= 1'b1;
            kind <= ~k;
        end
        @(posedge clock);
        start <= 1'b0;
        repeat (n - 3) @(posedge clock);
    endtask : run_op

    task automatic complete_run();
        $display("checked %0d values, %0d wrong", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run

    // ----------------------------------------
    // monitor: one note per bus cycle
    // ----------------------------------------
    always @(negedge clock) begin
        if (!rst && busy === 1'b1) begin
            if (notes.size() == 0) begin
                miscompares++;
                $display("wrong value at %0t: bus cycle with none expected", $time);
            end else begin
                oldest = notes.pop_front();
                check({vaq, readSelect, addressBus, oldest[26] ? dataOut : 8'h00},
                      oldest[25:0]);
            end
        end
        if (done === 1'b1) dones++;
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h99b21ccf));
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        // operand byte ff: wide store carries into 0100, jump offset wraps low byte
        for (int k = 0; k < 4; k++) begin
            run_op(k[1:0], 16'h20e2, 8'ha5, 16'hbeef, 16'h12f0, 1'b1);
        end
        repeat (3) @(posedge clock);
        $display("test directed back to back done");
        for (int i = 0; i < 60; i++) begin
            run_op(2'($urandom_range(3, 0)), 16'h1000 + 16'($urandom_range(16'hdffe, 0)),
                   8'($urandom), 16'($urandom), 16'($urandom), 1'($urandom_range(1, 0)));
            if ($urandom_range(1, 0) == 1) repeat (2) @(posedge clock);
        end
        for (int w = 0; w < 20 && (notes.size() != 0 || busy !== 1'b0); w++) begin
            @(posedge clock);
        end
        repeat (2) @(posedge clock);
        // a drain wait that ran out, or a sequence still running, counts as a mismatch
        if (notes.size() != 0 || busy !== 1'b0) miscompares++;
        check(26'(dones), 26'(ops));
        $display("test random sequences done");
        complete_run();
    end
endmodule : bus_cycle_sequencer_direct_indexed_tb_top
